//--- include/pdsa_regs.vh
// Constants for the program/data space access unit
`ifndef PDSA_REGS_VH
`define PDSA_REGS_VH
`define PDSA_PC_STEP        23'h000002
`define PDSA_EA_MSB         15
`define PDSA_WIN_LO_BITS    15
`define PDSA_PAGE_CFG_BIT   7
`define PDSA_OP_NONE        3'h0
`define PDSA_OP_RD_LOW      3'h1
`define PDSA_OP_RD_HIGH     3'h2
`define PDSA_OP_WR_LOW      3'h3
`define PDSA_OP_WR_HIGH     3'h4
`define PDSA_CLS_MOVE       2'h0
`define PDSA_CLS_DMOVE      2'h1
`define PDSA_CLS_DSP_PF     2'h2
`define PDSA_CLS_OTHER      2'h3
`define PDSA_WIN_EXTRA_FAST 2'h1
`define PDSA_WIN_EXTRA_SLOW 2'h2
`define PDSA_WIN_EXTRA_NONE 2'h0
`define PDSA_Y_START_RST    16'h0800
`define PDSA_Y_END_RST      16'h0fff
`define PDSA_IMPL_END_RST   16'h0fff
`define PDSA_ZERO_WORD      16'h0000
`endif

//--- rtl/pdsa_decode.v
// Fixed X/Y space and implemented-memory decode
`timescale 1ns/10ps
`include "pdsa_regs.vh"
module pdsa_decode #(
  parameter [15:0] Y_START  = `PDSA_Y_START_RST,
  parameter [15:0] Y_END    = `PDSA_Y_END_RST,
  parameter [15:0] IMPL_END = `PDSA_IMPL_END_RST
) (
  // Address under test
  input  wire [15:0] i_ea,
  // Decode results
  output wire        o_in_y,
  output wire        o_impl
);
  // Boundary is fixed by parameters, no software path alters it
  assign o_in_y = (i_ea >= Y_START) && (i_ea <= Y_END);
  assign o_impl = (i_ea <= IMPL_END);
endmodule // pdsa_decode

//--- rtl/pdsa_wincost.v
// Extra-cycle cost of a program window access
`timescale 1ns/10ps
`include "pdsa_regs.vh"
module pdsa_wincost (
  // Access description
  input  wire       i_win,
  input  wire [1:0] i_cls,
  input  wire       i_in_rpt,
  input  wire       i_rpt_edge,
  // Cost
  output reg  [1:0] o_extra
);
  // Edge iterations (first, last, irq exit, re-entry) pay two
  always @* begin
    o_extra = `PDSA_WIN_EXTRA_NONE;
    if (i_win) begin
      if (i_in_rpt) begin
        o_extra = i_rpt_edge ? `PDSA_WIN_EXTRA_SLOW : `PDSA_WIN_EXTRA_NONE;
      end else if (i_cls == `PDSA_CLS_OTHER) begin
        o_extra = `PDSA_WIN_EXTRA_SLOW;
      end else begin
        o_extra = `PDSA_WIN_EXTRA_FAST;
      end
    end
  end
endmodule // pdsa_wincost

//--- rtl/pdsa_top.v
// Program/data space access unit: table, window and X/Y routing
`timescale 1ns/10ps
`include "pdsa_regs.vh"
module pdsa_top (
  // Clock and reset
  input  wire        i_ref_clk,
  input  wire        i_rst_b,
  // Program counter control
  input  wire        i_pc_adv,
  input  wire        i_pc_load,
  input  wire [22:0] i_pc_load_val,
  // Core control and page registers
  input  wire        i_program_window_enable,
  input  wire [7:0]  i_program_window_page,
  input  wire [7:0]  i_table_page,
  // Table access request
  input  wire [2:0]  i_table_op,
  input  wire        i_table_byte,
  input  wire [15:0] i_table_ea,
  input  wire [15:0] i_table_wdata,
  // X data path request
  input  wire        i_x_rd,
  input  wire        i_x_wr,
  input  wire        i_x_byte,
  input  wire [15:0] i_x_ea,
  input  wire [15:0] i_x_wdata,
  input  wire        i_x_modulo,
  input  wire        i_x_bitrev,
  input  wire [15:0] i_mod_start,
  input  wire [15:0] i_mod_end,
  input  wire [15:0] i_bitrev_mask,
  // Instruction context
  input  wire        i_dsp_class,
  input  wire [1:0]  i_instr_cls,
  input  wire        i_in_rpt,
  input  wire        i_rpt_edge,
  // Y prefetch request
  input  wire        i_y_rd,
  input  wire [15:0] i_y_ea,
  input  wire        i_y_modulo,
  // Memory return data
  input  wire [23:0] i_prog_rdata,
  input  wire [15:0] i_xmem_rdata,
  input  wire [15:0] i_ymem_rdata,
  // Program memory port
  output reg  [22:0] o_pc,
  output reg         o_prog_rd,
  output reg         o_prog_wr_low,
  output reg         o_prog_wr_high,
  output reg  [23:0] o_prog_addr,
  output reg         o_prog_cfg,
  output reg  [15:0] o_prog_wdata,
  // X memory port
  output reg         o_xmem_rd,
  output reg         o_xmem_wr,
  output reg  [1:0]  o_xmem_be,
  output reg  [15:0] o_xmem_addr,
  output reg  [15:0] o_xmem_wdata,
  // Y memory port (read only)
  output reg         o_ymem_rd,
  output reg  [15:0] o_ymem_addr,
  // Results
  output reg  [15:0] o_table_rdata,
  output reg  [15:0] o_x_rdata,
  output reg  [15:0] o_y_rdata,
  output reg  [1:0]  o_win_extra,
  output reg         o_win_active
);

  // Modulo wrap shared by X and Y address paths
  function [15:0] mod_wrap;
    input [15:0] ea;
    input        en;
    input [15:0] lo;
    input [15:0] hi;
    begin
      // Bounds are word addresses, so the wrap steps by two
      if (en && (ea > hi)) begin
        mod_wrap = lo + (ea - hi) - 16'h0002;
      end else if (en && (ea < lo)) begin
        mod_wrap = hi - (lo - ea) + 16'h0002;
      end else begin
        mod_wrap = ea;
      end
    end
  endfunction

  // Bit-reverse the masked field of a write address
  function [15:0] bit_rev;
    input [15:0] ea;
    input [15:0] mask;
    integer k;
    reg [15:0] r;
    begin
      // Field mirrors around bit 8; bit 0 is always kept
      r = ea;
      for (k = 1; k < 16; k = k + 1) begin
        if (mask[k]) begin
          r[k] = ea[16 - k];
        end
      end
      bit_rev = r;
    end
  endfunction

  // Byte lane pick shared by table low reads and X byte reads
  function [15:0] byte_pick;
    input [15:0] word;
    input        sel;
    begin
      if (sel) begin
        byte_pick = {8'h00, word[15:8]};
      end else begin
        byte_pick = {8'h00, word[7:0]};
      end
    end
  endfunction

  // Decode and cost results
  wire        x_in_y;
  wire        x_impl;
  wire        y_in_y;
  wire        y_impl;
  wire [1:0]  extra_w;

  // Combinational shaping of the current request
  reg         win_hit;
  reg         tbl_rd;
  reg  [15:0] x_ea_eff;
  reg  [15:0] y_ea_eff;
  reg         x_ok;
  reg         y_ok;
  reg  [22:0] pc_nxt;

  // Request state carried into the data return cycle
  reg         table_busy_r;
  reg         win_pend_r;
  reg  [2:0]  tbl_op_r;
  reg         tbl_byte_r;
  reg         tbl_lsb_r;
  reg         x_byte_r;
  reg         x_lsb_r;
  reg         x_rd_pend_r;
  reg         x_ok_r;
  reg         y_rd_pend_r;
  reg         y_ok_r;

  // Fixed decodes for both address paths
  pdsa_decode u_dec_x (
    .i_ea   (x_ea_eff),
    .o_in_y (x_in_y),
    .o_impl (x_impl)
  );
  pdsa_decode u_dec_y (
    .i_ea   (y_ea_eff),
    .o_in_y (y_in_y),
    .o_impl (y_impl)
  );

  // Cost of a window access for the pipeline stall logic
  pdsa_wincost u_cost (
    .i_win      (win_hit),
    .i_cls      (i_instr_cls),
    .i_in_rpt   (i_in_rpt),
    .i_rpt_edge (i_rpt_edge),
    .o_extra    (extra_w)
  );

  // Program counter, always even, two bytes per instruction word
  always @* begin
    pc_nxt = o_pc;
    if (i_pc_load) begin
      pc_nxt = {i_pc_load_val[22:1], 1'b0};
    end else if (i_pc_adv) begin
      pc_nxt = o_pc + `PDSA_PC_STEP;
    end
  end

  // Address shaping and access classification
  always @* begin
    tbl_rd   = (i_table_op == `PDSA_OP_RD_LOW) || (i_table_op == `PDSA_OP_RD_HIGH);
    // Modulo on X reads and plain writes; a bit-reversed X write takes the reversed EA, no modulo
    x_ea_eff = mod_wrap(i_x_ea, i_x_modulo, i_mod_start, i_mod_end);
    if (i_x_wr && i_x_bitrev) begin
      x_ea_eff = bit_rev(i_x_ea, i_bitrev_mask);
    end
    y_ea_eff = mod_wrap(i_y_ea, i_y_modulo, i_mod_start, i_mod_end);
    // Window is blocked while a table op runs or is requested
    win_hit  = i_program_window_enable && x_ea_eff[`PDSA_EA_MSB] && i_x_rd
               && !table_busy_r && (i_table_op == `PDSA_OP_NONE);
    // DSP X reads lose the Y block; others see all implemented memory, Y block included
    x_ok     = x_impl && !(i_dsp_class && x_in_y);
    // Y path is only for DSP prefetch and only inside Y
    y_ok     = i_dsp_class && y_in_y && y_impl;
  end

  // Registered memory strobes and addresses
  always @(posedge i_ref_clk or negedge i_rst_b) begin
    if (!i_rst_b) begin
      o_pc           <= 23'h000000;
      o_prog_rd      <= 1'b0;
      o_prog_wr_low  <= 1'b0;
      o_prog_wr_high <= 1'b0;
      o_prog_addr    <= 24'h000000;
      o_prog_cfg     <= 1'b0;
      o_prog_wdata   <= 16'h0000;
      o_xmem_rd      <= 1'b0;
      o_xmem_wr      <= 1'b0;
      o_xmem_be      <= 2'h0;
      o_xmem_addr    <= 16'h0000;
      o_xmem_wdata   <= 16'h0000;
      o_ymem_rd      <= 1'b0;
      o_ymem_addr    <= 16'h0000;
      o_win_extra    <= 2'h0;
      o_win_active   <= 1'b0;
      table_busy_r   <= 1'b0;
      win_pend_r     <= 1'b0;
      tbl_op_r       <= 3'h0;
      tbl_byte_r     <= 1'b0;
      tbl_lsb_r      <= 1'b0;
      x_byte_r       <= 1'b0;
      x_lsb_r        <= 1'b0;
      x_rd_pend_r    <= 1'b0;
      x_ok_r         <= 1'b0;
      y_rd_pend_r    <= 1'b0;
      y_ok_r         <= 1'b0;
    end else begin
      o_pc           <= pc_nxt;
      table_busy_r   <= (i_table_op != `PDSA_OP_NONE);
      tbl_op_r       <= i_table_op;
      tbl_byte_r     <= i_table_byte;
      tbl_lsb_r      <= i_table_ea[0];
      win_pend_r     <= win_hit;
      o_win_active   <= win_hit;
      o_win_extra    <= extra_w;
      // Write strobes stand one cycle per request cycle
      o_prog_wr_low  <= (i_table_op == `PDSA_OP_WR_LOW);
      o_prog_wr_high <= (i_table_op == `PDSA_OP_WR_HIGH);
      o_prog_wdata   <= i_table_wdata;
      // Table path owns the program port; window only when idle
      if (i_table_op != `PDSA_OP_NONE) begin
        o_prog_rd   <= tbl_rd;
        o_prog_addr <= {i_table_page, i_table_ea};
        o_prog_cfg  <= i_table_page[`PDSA_PAGE_CFG_BIT];
      end else if (win_hit) begin
        o_prog_rd   <= 1'b1;
        o_prog_addr <= {1'b0, i_program_window_page, x_ea_eff[`PDSA_WIN_LO_BITS-1:0]};
        o_prog_cfg  <= 1'b0;
      end else begin
        o_prog_rd   <= 1'b0;
      end
      // X bus carries every write to implemented memory, Y block included
      o_xmem_wr    <= i_x_wr && x_impl;
      o_xmem_wdata <= i_x_wdata;
      o_xmem_be    <= i_x_byte ? (x_ea_eff[0] ? 2'h2 : 2'h1) : 2'h3;
      o_xmem_rd    <= i_x_rd && !win_hit && x_ok;
      o_xmem_addr  <= x_ea_eff;
      // What the return cycle must do with the X answer
      x_rd_pend_r  <= i_x_rd && !win_hit;
      x_ok_r       <= x_ok;
      x_byte_r     <= i_x_byte;
      x_lsb_r      <= x_ea_eff[0];
      // Y bus only reads, concurrently with the X read
      o_ymem_rd    <= i_y_rd && y_ok;
      o_ymem_addr  <= y_ea_eff;
      y_rd_pend_r  <= i_y_rd;
      y_ok_r       <= y_ok;
    end
  end

  // Return data, one cycle after the memories answer
  always @(posedge i_ref_clk or negedge i_rst_b) begin
    if (!i_rst_b) begin
      o_table_rdata <= 16'h0000;
      o_x_rdata     <= 16'h0000;
      o_y_rdata     <= 16'h0000;
    end else begin
      // Only the high table read exposes bits 23:16
      case (tbl_op_r)
        `PDSA_OP_RD_LOW: begin
          // Byte select is the table EA LSb, as for data space bytes
          if (tbl_byte_r) begin
            o_table_rdata <= byte_pick(i_prog_rdata[15:0], tbl_lsb_r);
          end else begin
            o_table_rdata <= i_prog_rdata[15:0];
          end
        end
        `PDSA_OP_RD_HIGH: begin
          // Misaligned word reads are not trapped here; the core does that
          if (tbl_byte_r && tbl_lsb_r) begin
            o_table_rdata <= `PDSA_ZERO_WORD;
          end else begin
            o_table_rdata <= {8'h00, i_prog_rdata[23:16]};
          end
        end
        // Hold the last table result between reads
        default: begin
          o_table_rdata <= o_table_rdata;
        end
      endcase
      // Window reads drop the upper program byte
      if (win_pend_r) begin
        o_x_rdata <= i_prog_rdata[15:0];
      end else if (x_rd_pend_r) begin
        if (!x_ok_r) begin
          o_x_rdata <= `PDSA_ZERO_WORD;
        end else if (x_byte_r) begin
          o_x_rdata <= byte_pick(i_xmem_rdata, x_lsb_r);
        end else begin
          o_x_rdata <= i_xmem_rdata;
        end
      end
      // Y answers zero outside its own block
      if (y_rd_pend_r) begin
        o_y_rdata <= y_ok_r ? i_ymem_rdata : `PDSA_ZERO_WORD;
      end
    end
  end

endmodule // pdsa_top

//--- testbench/pdsa_top_sva.sv
// Port-level assertions for the access unit
`timescale 1ns/10ps
module pdsa_top_sva (
  // Clock, reset and requests
  input logic        i_ref_clk,
  input logic        i_rst_b,
  input logic        i_pc_adv,
  input logic        i_pc_load,
  input logic [2:0]  i_table_op,
  input logic        i_table_byte,
  input logic [15:0] i_table_ea,
  input logic [7:0]  i_table_page,
  input logic        i_program_window_enable,
  input logic [7:0]  i_program_window_page,
  input logic        i_x_rd,
  input logic [15:0] i_x_ea,
  input logic [1:0]  i_instr_cls,
  input logic        i_in_rpt,
  input logic        i_rpt_edge,
  input logic [23:0] i_prog_rdata,
  // Outputs watched
  input logic [22:0] o_pc,
  input logic        o_prog_rd,
  input logic [23:0] o_prog_addr,
  input logic        o_prog_cfg,
  input logic [15:0] o_table_rdata,
  input logic [1:0]  o_win_extra,
  input logic        o_win_active
);
  default clocking cb @(posedge i_ref_clk); endclocking
  default disable iff (!i_rst_b);
  // Table op last cycle keeps the window off one cycle longer
  logic prev_tbl_r;
  always_ff @(posedge i_ref_clk or negedge i_rst_b) begin
    if (!i_rst_b) prev_tbl_r <= 1'b0;
    else prev_tbl_r <= (i_table_op != 3'h0);
  end
  wire [15:0] prog_lo = i_prog_rdata[15:0];
  wire [7:0]  prog_hi = i_prog_rdata[23:16];
  wire [14:0] x_lo    = i_x_ea[14:0];
  wire        win_req = i_program_window_enable && i_x_rd && i_x_ea[15] && i_table_op == 3'h0 && !prev_tbl_r;
  // Table read: request edge, then the memory answer cycle
  sequence s_rdl(b); i_table_op == 3'h1 && i_table_byte == b ##1 1'b1; endsequence
  sequence s_rdh(b); i_table_op == 3'h2 && i_table_byte == b && (!b || i_table_ea[0]) ##1 1'b1; endsequence
  a_pc_step_two: assert property (i_pc_adv && !i_pc_load |=> o_pc == $past(o_pc) + 23'h000002)
    else $error("pc step wrong");
  a_tbl_addr_page: assert property (i_table_op != 3'h0 |=> o_prog_addr == {$past(i_table_page), $past(i_table_ea)} && o_prog_cfg == o_prog_addr[23])
    else $error("table address wrong");
  a_rdl_word_data: assert property (s_rdl(1'b0) |=> o_table_rdata == $past(prog_lo))
    else $error("low word read wrong");
  a_rdh_word_data: assert property (s_rdh(1'b0) |=> o_table_rdata == {8'h00, $past(prog_hi)})
    else $error("high word read wrong");
  a_rdh_byte_zero: assert property (s_rdh(1'b1) |=> o_table_rdata == 16'h0000)
    else $error("high byte not zero");
  a_win_redirect: assert property (win_req |=> o_win_active && o_prog_rd && o_prog_addr == {1'b0, $past(i_program_window_page), $past(x_lo)})
    else $error("window address wrong");
  a_win_suspend: assert property (i_table_op != 3'h0 |=> !o_win_active ##1 !o_win_active)
    else $error("window during table op");
  a_win_cost: assert property (o_win_active |-> o_win_extra == ($past(i_in_rpt) ? ($past(i_rpt_edge) ? 2'h2 : 2'h0) : ($past(i_instr_cls) == 2'h3 ? 2'h2 : 2'h1)))
    else $error("window cost wrong");
endmodule // pdsa_top_sva
bind pdsa_top pdsa_top_sva u_sva (.*);

//--- testbench/pdsa_mem_model.sv
// Behavioural program, X and Y memories behind the unit
`timescale 1ns/10ps
module pdsa_mem_model (
  // Clock
  input  logic        i_ref_clk,
  // Strobes and addresses
  input  logic        i_prog_rd,
  input  logic [23:0] i_prog_addr,
  input  logic        i_xmem_rd,
  input  logic [15:0] i_xmem_addr,
  input  logic        i_ymem_rd,
  input  logic [15:0] i_ymem_addr,
  // Read data
  output logic [23:0] o_prog_rdata,
  output logic [15:0] o_xmem_rdata,
  output logic [15:0] o_ymem_rdata
);
  // Idle pattern flips each cycle so stale data never passes as an answer
  logic [23:0] junk_r = 24'h96e1d2;
  always @(posedge i_ref_clk) junk_r <= ~junk_r;
  // Data stands during the strobe cycle, as the unit samples it then
  assign o_prog_rdata = i_prog_rd ? {i_prog_addr[7:0] ^ 8'h3c, i_prog_addr[15:0] ^ 16'hc3a5} : junk_r;
  assign o_xmem_rdata = i_xmem_rd ? i_xmem_addr ^ 16'h5a0f : junk_r[15:0];
  assign o_ymem_rdata = i_ymem_rd ? i_ymem_addr ^ 16'h0ff0 : junk_r[23:8];
endmodule // pdsa_mem_model

//--- testbench/tb_pdsa_top.sv
// Self-checking bench for the access unit
`timescale 1ns/10ps
module tb_pdsa_top;
  // Stimulus, idle at time zero
  logic        i_ref_clk = 1'b0, i_rst_b = 1'b0, i_pc_adv = 1'b0, i_pc_load = 1'b0;
  logic [22:0] i_pc_load_val = 23'h000000;
  logic        i_program_window_enable = 1'b0, i_table_byte = 1'b0, i_x_rd = 1'b0, i_x_wr = 1'b0;
  logic        i_x_byte = 1'b0, i_x_modulo = 1'b0, i_x_bitrev = 1'b0, i_dsp_class = 1'b0;
  logic        i_in_rpt = 1'b0, i_rpt_edge = 1'b0, i_y_rd = 1'b0, i_y_modulo = 1'b0;
  logic [7:0]  i_program_window_page = 8'h00, i_table_page = 8'h00;
  logic [2:0]  i_table_op = 3'h0;
  logic [1:0]  i_instr_cls = 2'h0;
  logic [15:0] i_table_ea = 16'h0000, i_table_wdata = 16'h0000, i_x_ea = 16'h0000, i_x_wdata = 16'h0000;
  logic [15:0] i_mod_start = 16'h0000, i_mod_end = 16'h0000, i_bitrev_mask = 16'h0000, i_y_ea = 16'h0000;
  wire  [23:0] i_prog_rdata, o_prog_addr;
  wire  [22:0] o_pc;
  wire  [15:0] i_xmem_rdata, i_ymem_rdata, o_prog_wdata, o_xmem_addr, o_xmem_wdata, o_ymem_addr;
  wire  [15:0] o_table_rdata, o_x_rdata, o_y_rdata;
  wire  [1:0]  o_xmem_be, o_win_extra;
  wire         o_prog_rd, o_prog_wr_low, o_prog_wr_high, o_prog_cfg, o_xmem_rd, o_xmem_wr, o_ymem_rd, o_win_active;
  int          num_errors = 0, comparisons = 0;
  always #12.5 i_ref_clk = ~i_ref_clk;
  pdsa_top u_dut (.*);
  pdsa_mem_model u_mem (.i_ref_clk(i_ref_clk), .i_prog_rd(o_prog_rd), .i_prog_addr(o_prog_addr),
    .i_xmem_rd(o_xmem_rd), .i_xmem_addr(o_xmem_addr), .i_ymem_rd(o_ymem_rd), .i_ymem_addr(o_ymem_addr),
    .o_prog_rdata(i_prog_rdata), .o_xmem_rdata(i_xmem_rdata), .o_ymem_rdata(i_ymem_rdata));
  // Program word the memory model holds at an address
  function automatic logic [23:0] pf(input logic [23:0] a);
    return {a[7:0] ^ 8'h3c, a[15:0] ^ 16'hc3a5};
  endfunction
  task chk(input string nm, input logic [23:0] seen, input logic [23:0] exp);
    comparisons++;
    if (seen !== exp) begin
      num_errors++;
      $display("ERROR %s expected %h seen %h", nm, exp, seen);
    end
  endtask
  // Drop strobes at the taking edge, then settle into cycle 1
  task go;
    @(posedge i_ref_clk);
    i_table_op <= 3'h0;
    i_x_rd <= 1'b0;
    i_x_wr <= 1'b0;
    i_y_rd <= 1'b0;
    i_dsp_class <= 1'b0;
    i_x_byte <= 1'b0;
    i_x_modulo <= 1'b0;
    i_x_bitrev <= 1'b0;
    i_y_modulo <= 1'b0;
    #1;
  endtask
  task nx;
    @(posedge i_ref_clk) #1;
  endtask
  task t_pc;
    @(posedge i_ref_clk) i_pc_load <= 1'b1;
    i_pc_load_val <= 23'h000101;
    @(posedge i_ref_clk) i_pc_load <= 1'b0;
    i_pc_adv <= 1'b1;
    #1 chk("pc_load", o_pc, 24'h000100);
    repeat (2) @(posedge i_ref_clk);
    i_pc_adv <= 1'b0;
    #1 chk("pc_step", o_pc, 24'h000104);
  endtask
  // Every table read kind, both byte selects, user and configuration pages
  task t_table;
    logic [23:0] a;
    logic [23:0] p;
    logic [15:0] e;
    for (int k = 0; k < 8; k++) begin
      a = {(k[0] ? 8'h95 : 8'h15), 13'h0953, k[1:0], k[2]};
      p = pf(a);
      e = k[1] ? ((k[0] && k[2]) ? 16'h0000 : {8'h00, p[23:16]})
               : (k[0] ? {8'h00, (k[2] ? p[15:8] : p[7:0])} : p[15:0]);
      @(posedge i_ref_clk);
      i_table_op <= k[1] ? 3'h2 : 3'h1;
      i_table_byte <= k[0];
      i_table_page <= a[23:16];
      i_table_ea <= a[15:0];
      go;
      chk("tbl_addr", o_prog_addr, a);
      chk("tbl_cfg", o_prog_cfg, a[23]);
      nx;
      chk("tbl_data", o_table_rdata, e);
    end
  endtask
  // Window reads over all classes and repeat positions
  task t_win;
    logic [15:0] ea;
    for (int k = 0; k < 16; k++) begin
      ea = {6'h21, k[3:0], 6'h0a};
      @(posedge i_ref_clk);
      i_program_window_enable <= 1'b1;
      i_program_window_page <= 8'h5c;
      i_x_rd <= 1'b1;
      i_x_ea <= ea;
      i_instr_cls <= k[1:0];
      i_in_rpt <= k[2];
      i_rpt_edge <= k[3];
      go;
      chk("win_addr", o_prog_addr, {9'h05c, ea[14:0]});
      chk("win_cost", o_win_extra, k[2] ? (k[3] ? 2'h2 : 2'h0) : (k[1:0] == 2'h3 ? 2'h2 : 2'h1));
      nx;
      chk("win_data", o_x_rdata, pf({9'h05c, ea[14:0]}) & 24'h00ffff);
    end
  endtask
  // Window held off by a table op, then disabled outright
  task t_susp;
    @(posedge i_ref_clk);
    i_table_op <= 3'h1;
    i_x_rd <= 1'b1;
    i_x_ea <= 16'h8010;
    @(posedge i_ref_clk) i_table_op <= 3'h0;
    #1 chk("win_tbl", o_win_active, 1'b0);
    go;
    chk("win_after", o_win_active, 1'b0);
    @(posedge i_ref_clk) i_program_window_enable <= 1'b0;
    i_x_rd <= 1'b1;
    go;
    chk("win_off", o_win_active, 1'b0);
    nx;
    chk("unimpl", o_x_rdata, 16'h0000);
  endtask
  task dsp(input logic d, input logic [15:0] xa, input logic [15:0] ya, input logic [15:0] ex, input logic [15:0] ey);
    @(posedge i_ref_clk);
    i_dsp_class <= d;
    i_x_rd <= 1'b1;
    i_x_ea <= xa;
    i_y_rd <= 1'b1;
    i_y_ea <= ya;
    go;
    nx;
    chk("x_data", o_x_rdata, ex);
    chk("y_data", o_y_rdata, ey);
  endtask
  // Write back into Y space still goes over the X write path
  task t_wr;
    @(posedge i_ref_clk);
    i_dsp_class <= 1'b1;
    i_x_wr <= 1'b1;
    i_x_ea <= 16'h0902;
    i_x_wdata <= 16'hbeef;
    go;
    chk("x_wr", {o_xmem_wr, o_ymem_rd, o_xmem_addr}, {2'h2, 16'h0902});
    chk("x_wdata", o_xmem_wdata, 16'hbeef);
  endtask
  // Table writes strobe the program port for one cycle each
  task t_twr;
    for (int k = 0; k < 2; k++) begin
      @(posedge i_ref_clk);
      i_table_op <= k[0] ? 3'h4 : 3'h3;
      i_table_page <= 8'h12;
      i_table_ea <= 16'h4ace;
      i_table_wdata <= 16'h1234 + k[15:0];
      go;
      chk("twr_strobe", {o_prog_wr_low, o_prog_wr_high, o_prog_rd}, {~k[0], k[0], 1'b0});
      chk("twr_addr", o_prog_addr, 24'h124ace);
      chk("twr_data", o_prog_wdata, 16'h1234 + k[15:0]);
    end
  endtask
  // X byte reads pick a lane by the EA LSb and zero the high byte
  task t_xbyte;
    logic [15:0] ea;
    for (int k = 0; k < 2; k++) begin
      ea = 16'h0340 + k[15:0];
      @(posedge i_ref_clk);
      i_x_rd <= 1'b1;
      i_x_byte <= 1'b1;
      i_x_ea <= ea;
      go;
      chk("xb_strobe", {o_xmem_rd, o_xmem_be, o_xmem_addr}, {1'b1, (k[0] ? 2'h2 : 2'h1), ea});
      nx;
      chk("xb_data", o_x_rdata, {8'h00, (k[0] ? 8'h59 : 8'h4f)});
    end
  endtask
  // Modulo wraps on both paths; bit reversal bends X writes only
  task t_mod;
    for (int k = 0; k < 2; k++) begin
      @(posedge i_ref_clk);
      i_mod_start <= 16'h0900;
      i_mod_end <= 16'h091e;
      i_bitrev_mask <= 16'hfffe;
      i_x_bitrev <= 1'b1;
      i_x_modulo <= 1'b1;
      i_x_rd <= ~k[0];
      i_x_wr <= k[0];
      i_x_ea <= k[0] ? 16'h4000 : 16'h0920;
      i_y_modulo <= 1'b1;
      i_dsp_class <= 1'b1;
      i_y_rd <= 1'b1;
      i_y_ea <= 16'h08fe;
      go;
      chk("mod_x", {o_xmem_wr, o_xmem_addr}, {k[0], (k[0] ? 16'h0004 : 16'h0900)});
      chk("mod_y", {o_ymem_rd, o_ymem_addr}, {1'b1, 16'h091e});
    end
  endtask
  task final_report;
    $display("Comparisons %0d mismatches %0d", comparisons, num_errors);
    if (num_errors == 0 && comparisons > 0) $display("Result: passed");
    else $display("Result: failed");
    $finish;
  endtask
  initial begin
    repeat (12) @(posedge i_ref_clk);
    i_rst_b <= 1'b1;
    t_pc;
    t_table;
    t_win;
    t_susp;
    dsp(1'b1, 16'h0904, 16'h0908, 16'h0000, 16'h06f8);
    dsp(1'b1, 16'h0104, 16'h0106, 16'h5b0b, 16'h0000);
    dsp(1'b0, 16'h0904, 16'h0908, 16'h530b, 16'h0000);
    dsp(1'b0, 16'h2000, 16'h0908, 16'h0000, 16'h0000);
    t_wr;
    t_twr;
    t_xbyte;
    t_mod;
    nx;
    final_report;
  end
  // Hang guard, far past the roughly 120 cycles of the run
  initial begin
    #100000;
    num_errors++;
    final_report;
  end
endmodule // tb_pdsa_top
